/* rtl/rpes_top.sv */
// module: power and reset sequencer for the wlan and second radio sections
//
// Summary of operation
// - wlan request high enables regulators, releases wlan
// - wlan request low holds wlan in reset
// - regulator enable is OR of both requests
// - second radio low: hold it in reset
// - power-on reset releases within 110 ms
`timescale 1ns/100ps
module rpes_top #(
    parameter int unsigned POR_CYCLES = rpes_pkg::POR_CYCLES,
    parameter int unsigned HOST_ACCESS_CYCLES = rpes_pkg::HOST_ACCESS_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wlan_power_request,
    input wire logic second_radio_power_request,
    output logic regulator_enable,
    output logic wlan_reset_n,
    output logic second_radio_reset_n,
    output logic por_active,
    output logic host_access_ready
);
    rpes_cnt_if cnt ();
    // sequencer state and registered output levels
    rpes_pkg::rpes_state_t state_reg;
    rpes_pkg::rpes_state_t state_next;
    logic reg_en_reg, reg_en_next;
    logic wlan_rst_n_reg, wlan_rst_n_next;
    logic radio_rst_n_reg, radio_rst_n_next;
    logic ready_reg, ready_next;
    logic [31:0] ready_cnt_reg, ready_cnt_next;
    // check-only age counter, saturates one past the longer window
    localparam int unsigned AGE_MAX = ((POR_CYCLES > HOST_ACCESS_CYCLES) ? POR_CYCLES : HOST_ACCESS_CYCLES) + 32'h0000_0001;
    logic [31:0] age_reg;
    logic [31:0] age_next;

    // window timer; it only runs while the sequencer sits in power-on reset
    rpes_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .cnt(cnt)
    );

    // =========================================
    // power-on reset window, counted once from reset release
    // counter is parked at zero once the window has closed, so it stays quiet while powered
    assign cnt.clear = (state_reg != rpes_pkg::RPES_POR);
    assign cnt.limit = POR_CYCLES;

    always_comb begin
        state_next = state_reg;
        reg_en_next = 1'b0;
        wlan_rst_n_next = 1'b0;
        radio_rst_n_next = 1'b0;
        case (state_reg)
            rpes_pkg::RPES_POR: begin
                // everything held until the window closes
                if (cnt.done) begin
                    state_next = rpes_pkg::RPES_OFF;
                end
            end
            rpes_pkg::RPES_OFF, rpes_pkg::RPES_ON: begin
                reg_en_next = wlan_power_request | second_radio_power_request;
                wlan_rst_n_next = wlan_power_request;
                // second radio reset follows its own request only
                radio_rst_n_next = second_radio_power_request;
                state_next = reg_en_next ? rpes_pkg::RPES_ON : rpes_pkg::RPES_OFF;
            end
            default: begin
                state_next = rpes_pkg::RPES_POR;
            end
        endcase
    end

    // =========================================
    // ready flag for host bus accesses; informative only, host keeps its own wait
    always_comb begin
        ready_cnt_next = ready_cnt_reg;
        ready_next = ready_reg;
        if (ready_cnt_reg < HOST_ACCESS_CYCLES) begin
            ready_cnt_next = ready_cnt_reg + 32'h0000_0001;
        end else begin
            ready_next = 1'b1;
        end
    end

    // sequencer state and output levels
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= rpes_pkg::RPES_POR;
            reg_en_reg <= 1'b0;
            wlan_rst_n_reg <= 1'b0;
            radio_rst_n_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            reg_en_reg <= reg_en_next;
            wlan_rst_n_reg <= wlan_rst_n_next;
            radio_rst_n_reg <= radio_rst_n_next;
        end
    end

    // ready flag and its counter; a reset in mid-run starts the wait again
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_reg <= 1'b0;
            ready_cnt_reg <= 32'h0000_0000;
        end else begin
            ready_reg <= ready_next;
            ready_cnt_reg <= ready_cnt_next;
        end
    end

    // outputs straight from flip-flops; por_active is a state decode
    assign regulator_enable = reg_en_reg;
    assign wlan_reset_n = wlan_rst_n_reg;
    assign second_radio_reset_n = radio_rst_n_reg;
    assign por_active = (state_reg == rpes_pkg::RPES_POR);
    assign host_access_ready = ready_reg;

    // =========================================
    // age since reset release; only the window checks below read it
    always_comb begin
        age_next = age_reg;
        if (age_reg < AGE_MAX) begin
            age_next = age_reg + 32'h0000_0001;
        end
    end

    // registered age, cleared by every reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            age_reg <= 32'h0000_0000;
        end else begin
            age_reg <= age_next;
        end
    end

    // =========================================
    // level checks: outputs follow the requests one edge later
    a_reg_en_or: assert property (@(posedge clk) disable iff (!reset_n)
        !por_active |=> regulator_enable == $past(wlan_power_request | second_radio_power_request))
        else $error("regulator enable not OR of requests");
    a_regs_on_any: assert property (@(posedge clk) disable iff (!reset_n)
        (!por_active && (wlan_power_request || second_radio_power_request)) |=> regulator_enable)
        else $error("regulators off with a request high");
    a_reg_off_both: assert property (@(posedge clk) disable iff (!reset_n)
        (!wlan_power_request && !second_radio_power_request) |=> !regulator_enable)
        else $error("regulators on with both requests low");
    a_reg_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
        regulator_enable |-> $past(wlan_power_request | second_radio_power_request))
        else $error("regulators on without a request");
    a_wlan_release: assert property (@(posedge clk) disable iff (!reset_n)
        (!por_active && wlan_power_request) |=> wlan_reset_n && regulator_enable)
        else $error("wlan not released");
    a_wlan_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !wlan_power_request |=> !wlan_reset_n)
        else $error("wlan not held in reset");
    a_wlan_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
        wlan_reset_n |-> $past(wlan_power_request))
        else $error("wlan released without a request");
    a_wlan_implies_reg: assert property (@(posedge clk) disable iff (!reset_n)
        wlan_reset_n |-> regulator_enable)
        else $error("wlan released with regulators off");
    a_radio_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (wlan_power_request && !second_radio_power_request) |=> !second_radio_reset_n)
        else $error("second radio not held in reset");
    a_radio_release: assert property (@(posedge clk) disable iff (!reset_n)
        (!por_active && second_radio_power_request) |=> second_radio_reset_n)
        else $error("second radio not released");
    a_radio_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
        second_radio_reset_n |-> $past(second_radio_power_request))
        else $error("second radio released without a request");
    a_radio_implies_reg: assert property (@(posedge clk) disable iff (!reset_n)
        second_radio_reset_n |-> regulator_enable)
        else $error("second radio released with regulators off");
    a_state_match: assert property (@(posedge clk) disable iff (!reset_n)
        regulator_enable == (state_reg == rpes_pkg::RPES_ON))
        else $error("sequencer state disagrees with regulator enable");

    // =========================================
    // power-on reset checks; the age counter gives a bound independent of the timer
    a_por_holds: assert property (@(posedge clk) disable iff (!reset_n)
        por_active |-> !regulator_enable && !wlan_reset_n && !second_radio_reset_n)
        else $error("outputs active during power-on reset");
    a_por_bound: assert property (@(posedge clk) disable iff (!reset_n)
        cnt.done |=> !por_active)
        else $error("power-on reset not released");
    a_por_limit: assert property (@(posedge clk) disable iff (!reset_n)
        (age_reg > POR_CYCLES) |-> !por_active)
        else $error("power-on reset held too long");
    a_por_min_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (age_reg <= POR_CYCLES) |-> por_active)
        else $error("power-on reset released early");
    a_por_exit_off: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(por_active) |-> !regulator_enable && !wlan_reset_n && !second_radio_reset_n)
        else $error("outputs active on the edge leaving power-on reset");

    // =========================================
    // host ready checks; the flag is advisory, the host still keeps its own wait
    a_ready_order: assert property (@(posedge clk) disable iff (!reset_n)
        host_access_ready |-> !por_active)
        else $error("host ready before reset release");
    a_ready_stays: assert property (@(posedge clk) disable iff (!reset_n)
        host_access_ready |=> host_access_ready)
        else $error("host ready dropped");
    a_ready_early: assert property (@(posedge clk) disable iff (!reset_n)
        (age_reg <= HOST_ACCESS_CYCLES) |-> !host_access_ready)
        else $error("host ready too early");
    a_ready_late: assert property (@(posedge clk) disable iff (!reset_n)
        (age_reg > HOST_ACCESS_CYCLES) |-> host_access_ready)
        else $error("host ready missing after the wait");

    // =========================================
    // coverage of the main power states
    c_wlan_on: cover property (@(posedge clk) disable iff (!reset_n) wlan_reset_n && second_radio_reset_n);
    c_wlan_only: cover property (@(posedge clk) disable iff (!reset_n) wlan_reset_n && !second_radio_reset_n);
    c_radio_only: cover property (@(posedge clk) disable iff (!reset_n) second_radio_reset_n && !wlan_reset_n);
    c_all_off: cover property (@(posedge clk) disable iff (!reset_n) $fell(regulator_enable));
    c_ready_seen: cover property (@(posedge clk) disable iff (!reset_n) $rose(host_access_ready));
endmodule

/* rtl/rpes_pkg.sv */
// package: constants for the radio power enable sequencer
package rpes_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned POR_MAX_MS = 110;
    localparam int unsigned OFF_MIN_MS = 10;
    localparam int unsigned HOST_ACCESS_MIN_MS = 150;
    // longest times round down
    localparam int unsigned POR_CYCLES = (CLK_HZ / 1000) * POR_MAX_MS;
    // least times round down as well
    localparam int unsigned OFF_CYCLES = (CLK_HZ / 1000) * OFF_MIN_MS;
    localparam int unsigned HOST_ACCESS_CYCLES = (CLK_HZ / 1000) * HOST_ACCESS_MIN_MS;
    localparam int unsigned CNT_W = 32;
    typedef enum logic [1:0] {
        RPES_POR,
        RPES_OFF,
        RPES_ON
    } rpes_state_t;
endpackage

/* rtl/rpes_cnt_if.sv */
// interface: counter control between sequencer and timer
`timescale 1ns/100ps
interface rpes_cnt_if;
    logic clear;
    logic [31:0] limit;
    logic done;
    modport ctrl (output clear, output limit, input done);
    modport timer (input clear, input limit, output done);
endinterface

/* rtl/rpes_timer.sv */
// module: saturating cycle timer
`timescale 1ns/100ps
module rpes_timer (
    input wire logic clk,
    input wire logic reset_n,
    rpes_cnt_if.timer cnt
);
    logic [31:0] count_reg;
    logic [31:0] count_next;

    // =========================================
    // count up until the limit, then hold
    always_comb begin
        count_next = count_reg;
        if (cnt.clear) begin
            count_next = 32'h0000_0000;
        end else if (count_reg < cnt.limit) begin
            count_next = count_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 32'h0000_0000;
        end else begin
            count_reg <= count_next;
        end
    end

    assign cnt.done = (count_reg >= cnt.limit) && !cnt.clear;
endmodule

/* dv/rpes_host_model.sv */
// host model: drives both power requests with random levels
`timescale 1ns/100ps
module rpes_host_model #(
    parameter int unsigned OFF_GAP = 8
) (
    input wire logic clk,
    input wire logic run,
    output logic wlan_power_request,
    output logic second_radio_power_request
);
    int unsigned gap = 0;
    logic [1:0] v;
    // ====================
    // request driver
    // off time shortened for sim; levels move on the falling edge only
    always @(negedge clk) begin
        v = 2'($urandom);
        if (gap != 0) begin
            gap--;
        end else if (run) begin
            if (v == 2'h0 && {wlan_power_request, second_radio_power_request} != 2'h0) begin
                gap = OFF_GAP;
            end
            {wlan_power_request, second_radio_power_request} = v;
        end else begin
            {wlan_power_request, second_radio_power_request} = 2'h0;
        end
    end
endmodule

/* dv/tb.sv */
// testbench: random power requests checked against a level model
`timescale 1ns/100ps
module tb;
    localparam int unsigned POR_SIM = 20;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic por_prev = 1'b1;
    logic wlan_power_request, second_radio_power_request;
    logic regulator_enable, wlan_reset_n, second_radio_reset_n, por_active, host_access_ready;
    int miscompares = 0;
    int cmp_count = 0;
    int por_len = 0;
    // ====================
    // clock and instances
    initial forever #50 clk = ~clk;
    rpes_top #(.POR_CYCLES(POR_SIM), .HOST_ACCESS_CYCLES(40)) u_rpes_top (.clk(clk), .reset_n(reset_n),
        .wlan_power_request(wlan_power_request), .second_radio_power_request(second_radio_power_request),
        .regulator_enable(regulator_enable), .wlan_reset_n(wlan_reset_n),
        .second_radio_reset_n(second_radio_reset_n), .por_active(por_active),
        .host_access_ready(host_access_ready));
    rpes_host_model u_rpes_host_model (.clk(clk), .run(run), .wlan_power_request(wlan_power_request),
        .second_radio_power_request(second_radio_power_request));
    task automatic check(string name, logic [2:0] seen, logic [2:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ====================
    // level model, checked after each edge has settled
    // first edge after the window still shows the held levels, so it is checked as held
    always @(posedge clk) begin
        #10;
        if (reset_n && por_active === 1'b1) por_len++;
        if (reset_n && !por_prev) begin
            check("outputs", {regulator_enable, wlan_reset_n, second_radio_reset_n},
                {wlan_power_request | second_radio_power_request, wlan_power_request,
                second_radio_power_request});
        end else begin
            check("held", {regulator_enable, wlan_reset_n, second_radio_reset_n}, 3'h0);
        end
        por_prev = !reset_n || por_active;
    end
    // requests keep toggling through the window, so they must be ignored
    task automatic boot();
        por_len = 0;
        reset_n = 1'b1;
        repeat (30) @(negedge clk);
        check("ready_early", {2'h0, host_access_ready}, 3'h0);
        repeat (30) @(negedge clk);
        check("por_len", {2'h0, por_len >= POR_SIM && por_len <= POR_SIM + 1}, 3'h1);
        check("ready", {2'h0, host_access_ready}, 3'h1);
        repeat (400) @(negedge clk);
    endtask
    initial begin
        void'($urandom(32'h0698));
        repeat (12) @(negedge clk);
        run = 1'b1;
        boot();
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        boot();
        stop_test();
    end
    // watchdog, about twice the expected run
    initial begin
        #(2000 * 100);
        miscompares++;
        stop_test();
    end
endmodule
